// *** src/stmis_pkg.sv ***
// Purpose: Shared constants for the serial interrupt source block.
// Assumes: 16-bit registers on a plain strobe port with word addresses.
// Notes:   Type vectors are ordered 5 down to 0 from highest priority.
package stmis_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  localparam int          LVL_W           = 8;
  localparam int          NPIN            = 6;
  localparam int          NTYPE           = 6;

  // Register word addresses.
  localparam logic [3:0]  ADDR_TX_CMD_STAT = 4'h0;
  localparam logic [3:0]  ADDR_TX_INT_CTRL = 4'h1;
  localparam logic [3:0]  ADDR_STAT_INT_CTRL = 4'h2;
  localparam logic [3:0]  ADDR_MISC_STAT  = 4'h3;
  localparam logic [3:0]  ADDR_DAISY_CTRL = 4'h4;
  localparam logic [3:0]  ADDR_INT_ENABLE = 4'h5;

  // Transmit status bit positions, shared by their arm bits.
  localparam int          POS_PREAMBLE    = 7;
  localparam int          POS_IDLE        = 6;
  localparam int          POS_ABORT       = 5;
  localparam int          POS_EOF         = 4;
  localparam int          POS_CRC         = 3;
  localparam int          POS_UNDERRUN    = 1;
  localparam logic [7:0]  TX_STAT_MASK    = 8'hfa;

  // Transmit command field and codes.
  localparam int          CMD_LSB         = 12;
  localparam int          IDLE_LSB        = 8;
  localparam logic [3:0]  CMD_SEL_LEVEL   = 4'h6;
  localparam logic [3:0]  CMD_PURGE_TX    = 4'h9;
  localparam logic [3:0]  CMD_PURGE_ALL   = 4'ha;
  localparam logic [2:0]  IDLE_FLAGS      = 3'h0;

  // Miscellaneous status positions, shared by their arm bits.
  localparam int          POS_CNT_UNDER   = 3;
  localparam int          POS_SYNC_LOSS   = 2;
  localparam int          POS_BAUD1       = 1;
  localparam int          POS_BAUD0       = 0;
  localparam int          PIN_LSB         = 4;

  // Interrupt type positions in daisy chain vectors.
  localparam int          TY_RX_STAT      = 5;
  localparam int          TY_RX_DATA      = 4;
  localparam int          TY_TX_STAT      = 3;
  localparam int          TY_TX_DATA      = 2;
  localparam int          TY_PIN          = 1;
  localparam int          TY_MISC         = 0;

  // Operation codes of the daisy chain control register, and the master enable bit position.
  localparam logic [1:0]  SVC_CLEAR       = 2'h2;
  localparam logic [1:0]  SVC_SET         = 2'h3;
  localparam logic [1:0]  PND_CLR_BOTH    = 2'h1;
  localparam logic [1:0]  PND_CLR         = 2'h2;
  localparam logic [1:0]  PND_SET         = 2'h3;
  localparam int          MIE_POS         = 15;

  // Reset values.
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [5:0]  RST_TYPES       = 6'h00;

endpackage : stmis_pkg

// *** src/stmis_top.sv ***
// Purpose: Transmit, pin and miscellaneous interrupt sources with daisy chain bits.
// Assumes: Event inputs are one-cycle pulses from logic on clk; pins are asynchronous.
// Notes:   All state freezes while ce is low, the pin synchronisers included.
//
// Summary of operation
// - Sync mode preamble completion sets preamble_done; armed rise sets transmit-status pending.
// - Idle sent flag: every flag/sync idle character, else only the first idle bit.
// - HDLC abort sent sets abort_sent_flag; armed rise sets transmit-status pending.
// - Sync mode closing flag sets end_of_frame_sent; preceding CRC sets check_sequence_sent.
// - Transmit FIFO empty when character needed sets transmit_underrun; armed sets pending.
// - Pending set only on armed rise; status holds until host writes one.
// - Six arm bits in low control byte gate pending, never touch status.
// - Transmit-data pending held set while empty count exceeds programmed level.
// - Transmit purge command sets transmit-data pending at once.
// - Request only with chain enable, type and master enable, no own or higher service.
// - FIFO loading clears nothing; host clears pending and service bits explicitly.
// - Rising and falling edges on six pins each armed, regardless of direction.
// - Reset clears latch-state bits; open data bit reads inverted pin level.
// - Open latch with edge latch set: latch, clear edge latch, set pin pending.
// - Latched data frozen until host writes one; pending edges relatch at once.
// - Armed counter underrun event sets its flag and miscellaneous pending.
// - Armed biphase sync loss sets its flag and miscellaneous pending.
// - Armed baud generator terminal counts set their flags and miscellaneous pending.
// - Writing one unlatches misc flag, or relatches if event recurred; arms gate.
// - Daisy control reads service bits 13-8 and pending bits 5-0, tops zero.
// - Upper op field: 0x none, 10 clear, 11 set selected service bits.
// - Lower op field: 00 none, 01 clear pending and service, 10 clear pending.
// - Lower op field 11 sets selected pending bits.
// - Priority: receive status, receive data, transmit status, transmit data, pin, misc.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module stmis_top
  import stmis_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Transmitter events and modes.
  input  wire logic              sync_mode,
  input  wire logic              hdlc_mode,
  input  wire logic              preamble_done_ev,
  input  wire logic              idle_active,
  input  wire logic              idle_sent_ev,
  input  wire logic              abort_sent_ev,
  input  wire logic              end_of_frame_ev,
  input  wire logic              check_sequence_ev,
  input  wire logic              underrun_ev,
  input  wire logic [LVL_W-1:0]  tx_empty_count,
  output logic                   tx_purge,
  output logic                   rx_purge,
  // Receive side pending requests handled elsewhere.
  input  wire logic              rx_status_set,
  input  wire logic              rx_data_set,
  // Miscellaneous events.
  input  wire logic              counter_underrun_ev,
  input  wire logic              biphase_mode,
  input  wire logic              pll_sync_loss_ev,
  input  wire logic              baud_gen_one_zero,
  input  wire logic              baud_gen_zero_zero,
  // Monitored pins: rx clock, tx clock, rx request, tx request, carrier, clear to send.
  input  wire logic [NPIN-1:0]   pins,
  // Daisy chain.
  input  wire logic              chain_enable_in,
  output logic                   int_req_b
);

  // Register state.
  logic [7:0]        tx_stat_q, tx_stat_d;
  logic [2:0]        idle_sel_q, idle_sel_d;
  logic              lvl_sel_q, lvl_sel_d;
  logic              idle_first_q, idle_first_d;
  logic [15:0]       tx_ctrl_q, tx_ctrl_d;
  logic [15:0]       stat_ctrl_q, stat_ctrl_d;
  logic [3:0]        misc_q, misc_d;
  logic [3:0]        recur_q, recur_d;
  logic [NTYPE-1:0]  ip_q, ip_d;
  logic [NTYPE-1:0]  ius_q, ius_d;
  logic [NTYPE-1:0]  ie_q, ie_d;
  logic              mie_q, mie_d;
  logic              tx_purge_q, tx_purge_d;
  logic              rx_purge_q, rx_purge_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              int_req_q, int_req_d;

  // Pin state.
  logic [NPIN-1:0]   pin_s1_q, pin_s2_q, pin_s3_q;
  logic              chain_s1_q, chain_s2_q;
  logic [NPIN-1:0]   edge_q, edge_d;
  logic [NPIN-1:0]   lu_q, lu_d;
  logic [NPIN-1:0]   pdat_q, pdat_d;

  // Decoded accesses.
  logic              wr_tcs, wr_tic, wr_sic, wr_mis, wr_dcc, wr_ien;
  logic [3:0]        cmd;
  logic [7:0]        tx_set, tx_kept, tx_rise;
  logic [3:0]        misc_ev;
  logic [NPIN-1:0]   rise, fall, pin_edge, unlatch;
  logic [NTYPE-1:0]  hw_ip_set, ius_wsel, ip_wsel, ius_mid;
  logic [NTYPE-1:0]  busy_above, want;

  always_comb
  begin
    wr_tcs = wr && (addr == ADDR_TX_CMD_STAT);
    wr_tic = wr && (addr == ADDR_TX_INT_CTRL);
    wr_sic = wr && (addr == ADDR_STAT_INT_CTRL);
    wr_mis = wr && (addr == ADDR_MISC_STAT);
    wr_dcc = wr && (addr == ADDR_DAISY_CTRL);
    wr_ien = wr && (addr == ADDR_INT_ENABLE);
    cmd    = wr_tcs ? wdata[CMD_LSB +: 4] : 4'h0;
  end

  // Transmit status and control.
  always_comb
  begin
    tx_set = 8'h00;
    tx_set[POS_PREAMBLE] = preamble_done_ev && sync_mode;
    // Bit-oriented idle reports only the first idle bit of an idle period.
    if (idle_sel_q == IDLE_FLAGS)
    begin
      tx_set[POS_IDLE] = idle_sent_ev;
    end
    else
    begin
      tx_set[POS_IDLE] = idle_sent_ev && !idle_first_q;
    end
    tx_set[POS_ABORT]    = abort_sent_ev && hdlc_mode;
    tx_set[POS_EOF]      = end_of_frame_ev && sync_mode;
    tx_set[POS_CRC]      = check_sequence_ev && sync_mode;
    tx_set[POS_UNDERRUN] = underrun_ev;
    // A host write of one clears, but a same-cycle event wins.
    tx_kept   = tx_stat_q & ~(wr_tcs ? wdata[7:0] : 8'h00);
    tx_stat_d = (tx_kept | tx_set) & TX_STAT_MASK;
    // Arm bits only steer the pending bit, never the status itself.
    tx_rise   = tx_set & ~tx_kept & tx_ctrl_q[7:0] & TX_STAT_MASK;
    idle_first_d = idle_active ? (idle_first_q || idle_sent_ev) : 1'b0;
    idle_sel_d = wr_tcs ? wdata[IDLE_LSB +: 3] : idle_sel_q;
    lvl_sel_d  = lvl_sel_q;
    if (cmd == CMD_SEL_LEVEL)
    begin
      lvl_sel_d = 1'b1;
    end
    else if (cmd != 4'h0)
    begin
      lvl_sel_d = 1'b0;
    end
    tx_purge_d = (cmd == CMD_PURGE_TX) || (cmd == CMD_PURGE_ALL);
    rx_purge_d = (cmd == CMD_PURGE_ALL);
    tx_ctrl_d  = tx_ctrl_q;
    if (wr_tic)
    begin
      tx_ctrl_d[7:0] = wdata[7:0];
      if (lvl_sel_q)
      begin
        tx_ctrl_d[15:8] = wdata[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_stat_q    <= RST_BYTE;
      idle_sel_q   <= IDLE_FLAGS;
      lvl_sel_q    <= 1'b0;
      idle_first_q <= 1'b0;
      tx_ctrl_q    <= RST_WORD;
      tx_purge_q   <= 1'b0;
      rx_purge_q   <= 1'b0;
    end
    else if (ce)
    begin
      tx_stat_q    <= tx_stat_d;
      idle_sel_q   <= idle_sel_d;
      lvl_sel_q    <= lvl_sel_d;
      idle_first_q <= idle_first_d;
      tx_ctrl_q    <= tx_ctrl_d;
      tx_purge_q   <= tx_purge_d;
      rx_purge_q   <= rx_purge_d;
    end
  end

  // Pin edge detection and latching.
  always_comb
  begin
    rise     = pin_s2_q & ~pin_s3_q;
    fall     = ~pin_s2_q & pin_s3_q;
    pin_edge = '0;
    for (int i = 0; i < NPIN; i++)
    begin
      // Edges are seen on the pad level, so pin direction does not matter.
      pin_edge[i] = (rise[i] && stat_ctrl_q[PIN_LSB + 2*i + 1])
                 || (fall[i] && stat_ctrl_q[PIN_LSB + 2*i]);
    end
    lu_d    = lu_q;
    edge_d  = edge_q | pin_edge;
    unlatch = '0;
    for (int i = 0; i < NPIN; i++)
    begin
      unlatch[i] = wr_mis && wdata[PIN_LSB + 2*i + 1];
      // An unlatch with edges waiting relatches in the same cycle, so no read sees a gap.
      if (unlatch[i] || !lu_q[i])
      begin
        lu_d[i]   = edge_q[i];
        edge_d[i] = edge_q[i] ? pin_edge[i] : edge_d[i];
      end
    end
    // Open data bits follow the pin inverted; an unlatch reopens them for one sample.
    pdat_d = (lu_q & ~unlatch & pdat_q) | ((~lu_q | unlatch) & ~pin_s2_q);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_s3_q   <= '0;
      chain_s1_q <= 1'b0;
      chain_s2_q <= 1'b0;
      edge_q     <= '0;
      lu_q       <= '0;
      pdat_q     <= '0;
    end
    else if (ce)
    begin
      pin_s1_q   <= pins;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      chain_s1_q <= chain_enable_in;
      chain_s2_q <= chain_s1_q;
      edge_q     <= edge_d;
      lu_q       <= lu_d;
      pdat_q     <= pdat_d;
    end
  end

  // Miscellaneous status.
  always_comb
  begin
    misc_ev = 4'h0;
    misc_ev[POS_CNT_UNDER] = counter_underrun_ev;
    misc_ev[POS_SYNC_LOSS] = pll_sync_loss_ev && biphase_mode;
    misc_ev[POS_BAUD1]     = baud_gen_one_zero;
    misc_ev[POS_BAUD0]     = baud_gen_zero_zero;
    // Unarmed sources never set a flag; disarming leaves flags alone.
    misc_ev   = misc_ev & stat_ctrl_q[3:0];
    misc_d    = misc_q | misc_ev;
    recur_d   = recur_q | (misc_ev & misc_q);
    if (wr_mis)
    begin
      // Unlatching relatches at once when the event came back meanwhile.
      misc_d  = (misc_q & ~wdata[3:0]) | (recur_q & wdata[3:0]) | misc_ev;
      recur_d = (recur_q & ~wdata[3:0]) | (misc_ev & misc_q & ~wdata[3:0]);
    end
    stat_ctrl_d = wr_sic ? wdata : stat_ctrl_q;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      misc_q      <= 4'h0;
      recur_q     <= 4'h0;
      stat_ctrl_q <= RST_WORD;
    end
    else if (ce)
    begin
      misc_q      <= misc_d;
      recur_q     <= recur_d;
      stat_ctrl_q <= stat_ctrl_d;
    end
  end

  // Pending, service and enable bits, and the interrupt request.
  always_comb
  begin
    hw_ip_set = RST_TYPES;
    hw_ip_set[TY_RX_STAT] = rx_status_set;
    hw_ip_set[TY_RX_DATA] = rx_data_set;
    hw_ip_set[TY_TX_STAT] = |tx_rise;
    // Level source: stays set while the FIFO has room above the level.
    hw_ip_set[TY_TX_DATA] = (tx_empty_count > tx_ctrl_q[15:8])
                         || tx_purge_d;
    hw_ip_set[TY_PIN]     = |((~lu_q | unlatch) & edge_q);
    hw_ip_set[TY_MISC]    = |misc_ev;
    ius_wsel = wr_dcc ? wdata[13:8] : RST_TYPES;
    ip_wsel  = wr_dcc ? wdata[5:0] : RST_TYPES;
    // Service op first, so a same-write clear-both overrides a set.
    ius_mid = ius_q;
    unique case (wdata[15:14])
      SVC_CLEAR: ius_mid = ius_q & ~ius_wsel;
      SVC_SET:   ius_mid = ius_q | ius_wsel;
      default:   ius_mid = ius_q;
    endcase
    ius_d = ius_mid;
    ip_d  = ip_q;
    unique case (wdata[7:6])
      PND_CLR_BOTH:
      begin
        ip_d  = ip_q & ~ip_wsel;
        ius_d = ius_mid & ~ip_wsel;
      end
      PND_CLR: ip_d = ip_q & ~ip_wsel;
      PND_SET: ip_d = ip_q | ip_wsel;
      default: ip_d = ip_q;
    endcase
    // Hardware set wins over a software clear in the same cycle.
    ip_d  = ip_d | hw_ip_set;
    ie_d  = wr_ien ? wdata[5:0] : ie_q;
    mie_d = wr_ien ? wdata[MIE_POS] : mie_q;
    // A type is blocked by its own or any higher priority service bit.
    busy_above[NTYPE-1] = ius_q[NTYPE-1];
    for (int i = NTYPE-2; i >= 0; i--)
    begin
      busy_above[i] = busy_above[i+1] | ius_q[i];
    end
    want      = ip_q & ie_q & ~busy_above;
    int_req_d = chain_s2_q && mie_q && (|want);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ip_q      <= RST_TYPES;
      ius_q     <= RST_TYPES;
      ie_q      <= RST_TYPES;
      mie_q     <= 1'b0;
      int_req_q <= 1'b0;
    end
    else if (ce)
    begin
      ip_q      <= ip_d;
      ius_q     <= ius_d;
      ie_q      <= ie_d;
      mie_q     <= mie_d;
      int_req_q <= int_req_d;
    end
  end

  // Read port: data stand only in the cycle after the strobe.
  always_comb
  begin
    rdata_d = RST_WORD;
    if (rd)
    begin
      unique case (addr)
        ADDR_TX_CMD_STAT:   rdata_d = {5'h00, idle_sel_q, tx_stat_q};
        ADDR_TX_INT_CTRL:   rdata_d = tx_ctrl_q;
        ADDR_STAT_INT_CTRL: rdata_d = stat_ctrl_q;
        ADDR_MISC_STAT:
        begin
          for (int i = 0; i < NPIN; i++)
          begin
            rdata_d[PIN_LSB + 2*i + 1] = lu_q[i];
            rdata_d[PIN_LSB + 2*i]     = pdat_q[i];
          end
          rdata_d[3:0] = misc_q;
        end
        ADDR_DAISY_CTRL:    rdata_d = {2'b00, ius_q, 2'b00, ip_q};
        ADDR_INT_ENABLE:    rdata_d = {mie_q, 9'h000, ie_q};
        default:            rdata_d = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= RST_WORD;
    end
    else if (ce)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata     = rdata_q;
  assign tx_purge  = tx_purge_q;
  assign rx_purge  = rx_purge_q;
  assign int_req_b = !int_req_q;

endmodule : stmis_top

// *** tb/stmis_assertions.sv ***
// Purpose: Port assertions for the serial interrupt source block.
// Assumes: ce stays high while these checks are meant to hold.
// Notes:   Inner bits are seen only through reads of the daisy chain register and through the request pin.
`timescale 1ns/1ps
module stmis_chk
  import stmis_pkg::*;
(
  // Clock, reset and register port.
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // Purge pulses and daisy chain.
  input wire logic              tx_purge,
  input wire logic              rx_purge,
  input wire logic              chain_enable_in,
  input wire logic              int_req_b
);
  logic dc_wr;
  logic dc_rd;
  logic tc_wr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  assign dc_wr = ce && wr && addr == ADDR_DAISY_CTRL;
  assign dc_rd = ce && rd && addr == ADDR_DAISY_CTRL;
  assign tc_wr = ce && wr && addr == ADDR_TX_CMD_STAT;
  a_rdata_quiet:
    assert property ($past(!(ce && rd) || addr > 4'h5) |-> rdata == 16'h0000)
    else $error("read data not zero outside its answer cycle");
  a_daisy_chain_control_tops:
    assert property ($past(dc_rd) |-> rdata[15:14] == 2'h0 && rdata[7:6] == 2'h0)
    else $error("chain register top bits not zero");
  a_purge_tx:
    assert property (tc_wr && wdata[15:12] == CMD_PURGE_TX |=> tx_purge && !rx_purge)
    else $error("transmit purge pulse wrong");
  a_purge_all:
    assert property (tc_wr && wdata[15:12] == CMD_PURGE_ALL |=> tx_purge && rx_purge)
    else $error("full purge pulses wrong");
  a_purge_cause:
    assert property (tx_purge || rx_purge |-> $past(tc_wr) && tx_purge)
    else $error("purge pulse without command");
  a_chain_gate:
    assert property ((!chain_enable_in)[*5] |-> int_req_b)
    else $error("request while chain input low");
  a_mie_gate:
    assert property (ce && wr && addr == ADDR_INT_ENABLE && !wdata[MIE_POS] |=> ##1 int_req_b)
    else $error("request with master enable off");
  a_ius_block:
    assert property (dc_wr && wdata == 16'hff00 |=> ##1 int_req_b)
    else $error("request while all types under service");
  a_ius_read:
    assert property (dc_wr && wdata == 16'hff00 ##1 dc_rd |=> rdata[13:8] == 6'h3f)
    else $error("service bits not set by upper op");
  a_both_clear:
    assert property (dc_wr && wdata == 16'h007f ##1 dc_rd |=> rdata[13:8] == 6'h00)
    else $error("service bits not cleared by lower op");
endmodule : stmis_chk
bind stmis_top stmis_chk u_chk (
  .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tx_purge(tx_purge), .rx_purge(rx_purge),
  .chain_enable_in(chain_enable_in), .int_req_b(int_req_b)
);

// *** tb/stmis_host.sv ***
// Purpose: Host model for the register port and the daisy chain input.
// Assumes: Each access starts just after a rising edge; the slave never waits.
// Notes:   Strobes drop at the taking edge, so accesses may follow with no gap.
`timescale 1ns/1ps
module stmis_host
  import stmis_pkg::*;
(
  // Register port.
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata,
  // Daisy chain.
  output logic                   chain_enable_in
);
  initial
  begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    chain_enable_in = 1'b1;
  end
  // Released lines show inverted values so stale data is never mistaken for fresh.
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    #1;
    q = rdata;
  endtask : acc
  task automatic set_level(input logic [7:0] lvl, input logic [7:0] arm);
    logic [15:0] q;
    acc(1'b1, ADDR_TX_CMD_STAT, {CMD_SEL_LEVEL, 12'h000}, q);
    acc(1'b1, ADDR_TX_INT_CTRL, {lvl, arm}, q);
  endtask : set_level
  task automatic svc_done(input logic [5:0] t);
    logic [15:0] q;
    acc(1'b1, ADDR_DAISY_CTRL, {8'h00, 2'h1, t}, q);
  endtask : svc_done
endmodule : stmis_host

// *** tb/stmis_top_test.sv ***
// Purpose: Self-checking bench for the serial interrupt source block.
// Assumes: The host model owns the register port and the chain input.
// Notes:   Pin waits are fixed because the synchroniser depth is fixed.
`timescale 1ns/1ps
module stmis_top_test
  import stmis_pkg::*;
;
  logic              clk, rst_b, wr, rd, chain_enable_in, int_req_b, tx_purge, rx_purge, smode;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, q;
  logic [LVL_W-1:0]  cnt, arm;
  logic [5:0]        pins;
  logic [3:0]        mev;
  logic [7:0]        tev;
  logic [11:0]       st;
  logic [31:0]       seed;
  int                errors, checks, k;
  stmis_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .chain_enable_in(chain_enable_in));
  stmis_top dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sync_mode(smode), .hdlc_mode(smode), .idle_active(1'b1),
    .preamble_done_ev(tev[POS_PREAMBLE]), .idle_sent_ev(tev[POS_IDLE]),
    .abort_sent_ev(tev[POS_ABORT]), .end_of_frame_ev(tev[POS_EOF]),
    .check_sequence_ev(tev[POS_CRC]), .underrun_ev(tev[POS_UNDERRUN]), .tx_empty_count(cnt),
    .tx_purge(tx_purge), .rx_purge(rx_purge), .rx_status_set(tev[2]), .rx_data_set(tev[0]),
    .counter_underrun_ev(mev[3]), .biphase_mode(1'b1), .pll_sync_loss_ev(mev[2]),
    .baud_gen_one_zero(mev[1]), .baud_gen_zero_zero(mev[0]), .pins(pins),
    .chain_enable_in(chain_enable_in), .int_req_b(int_req_b));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [15:0] pv(input int i, input logic l, input logic d);
    return {14'h0000, l, d} << (4 + 2 * i);
  endfunction : pv
  function automatic logic [11:0] dop(input logic [11:0] s, input logic [15:0] w);
    logic [5:0] v;
    logic [5:0] p;
    v = s[11:6];
    p = s[5:0];
    if (w[15])
      v = w[14] ? (v | w[13:8]) : (v & ~w[13:8]);
    if (w[7:6] == 2'h1)
      v = v & ~w[5:0];
    if (w[7:6] == 2'h1 || w[7:6] == 2'h2)
      p = p & ~w[5:0];
    if (w[7:6] == 2'h3)
      p = p | w[5:0];
    return {v, p};
  endfunction : dop
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q);
  endtask : wrr
  task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    host.acc(1'b0, a, 16'h0000, q);
    chk_word(q & m, e);
  endtask : rdc
  task automatic pulse(input logic [7:0] t, input logic [3:0] m);
    tev <= t;
    mev <= m;
    @(posedge clk);
    tev <= 8'h00;
    mev <= 4'h0;
    @(posedge clk);
    #1;
  endtask : pulse
  task automatic setc(input logic [7:0] v);
    cnt <= v;
    @(posedge clk);
    #1;
  endtask : setc
  task automatic pin(input int i, input logic v);
    pins[i] <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask : pin
  // The request pin may take a few cycles through the chain synchroniser.
  task automatic want_req(input logic e);
    int n;
    n = 0;
    while (int_req_b !== e && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_word({15'h0000, int_req_b}, {15'h0000, e});
  endtask : want_req
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  initial
  begin
    errors = 0;
    checks = 0;
    seed = 32'h38fbb26a;
    rst_b = 1'b0;
    tev = 8'h00;
    smode = 1'b1;
    mev = 4'h0;
    pins = 6'h00;
    cnt = 8'h00;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    for (k = 0; k < 8; k++)
      rdc(k[3:0], 16'hffff, (k == 3) ? 16'h5550 : 16'h0000);
    pulse(8'h05, 4'h0);
    rdc(ADDR_DAISY_CTRL, 16'hffff, 16'h0030);
    wrr(ADDR_DAISY_CTRL, 16'hff00);
    rdc(ADDR_DAISY_CTRL, 16'hffff, 16'h3f30);
    wrr(ADDR_DAISY_CTRL, 16'h007f);
    rdc(ADDR_DAISY_CTRL, 16'hffff, 16'h0000);
    st = 12'h000;
    for (k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      wdata_mix: begin
        st = dop(st, {k[3:2], seed[13:8], k[1:0], seed[5:0]});
        wrr(ADDR_DAISY_CTRL, {k[3:2], seed[13:8], k[1:0], seed[5:0]});
      end
      rdc(ADDR_DAISY_CTRL, 16'hffff, {2'h0, st[11:6], 2'h0, st[5:0]});
    end
    wrr(ADDR_DAISY_CTRL, 16'h007f);
    for (k = 0; k < 8; k++)
    begin
      if (TX_STAT_MASK[k])
      begin
        seed = xs(seed);
        arm = seed[7:0] & TX_STAT_MASK;
        wrr(ADDR_TX_INT_CTRL, {8'h00, arm});
        pulse(8'(1 << k), 4'h0);
        rdc(ADDR_TX_CMD_STAT, 16'h00ff, 16'(1 << k));
        rdc(ADDR_DAISY_CTRL, 16'h0008, {12'h000, arm[k], 3'h0});
        wrr(ADDR_DAISY_CTRL, 16'h0088);
        pulse(8'(1 << k), 4'h0);
        rdc(ADDR_DAISY_CTRL, 16'h0008, 16'h0000);
        wrr(ADDR_TX_CMD_STAT, 16'(1 << k));
        rdc(ADDR_TX_CMD_STAT, 16'h00ff, 16'h0000);
      end
    end
    // Outside the framed modes only the underrun and idle sources may report.
    smode <= 1'b0;
    pulse(8'hba, 4'h0);
    smode <= 1'b1;
    rdc(ADDR_TX_CMD_STAT, 16'h00ff, 16'h0002);
    wrr(ADDR_TX_CMD_STAT, 16'h0102);
    pulse(8'h40, 4'h0);
    rdc(ADDR_TX_CMD_STAT, 16'h00ff, 16'h0000);
    host.set_level(8'h1b, 8'h00);
    setc(8'h1b);
    rdc(ADDR_DAISY_CTRL, 16'h0004, 16'h0000);
    setc(8'h1c);
    rdc(ADDR_DAISY_CTRL, 16'h0004, 16'h0004);
    wrr(ADDR_INT_ENABLE, 16'h8004);
    want_req(1'b0);
    host.chain_enable_in <= 1'b0;
    want_req(1'b1);
    repeat (3) @(posedge clk);
    host.chain_enable_in <= 1'b1;
    want_req(1'b0);
    wrr(ADDR_DAISY_CTRL, 16'hc100);
    wrr(ADDR_DAISY_CTRL, 16'he000);
    want_req(1'b1);
    wrr(ADDR_DAISY_CTRL, 16'ha000);
    want_req(1'b0);
    wrr(ADDR_DAISY_CTRL, 16'hc400);
    want_req(1'b1);
    host.svc_done(6'h05);
    want_req(1'b0);
    wrr(ADDR_INT_ENABLE, 16'h0004);
    want_req(1'b1);
    setc(8'h00);
    for (k = 0; k < 2; k++)
    begin
      wrr(ADDR_DAISY_CTRL, 16'h0084);
      rdc(ADDR_DAISY_CTRL, 16'h0004, 16'h0000);
      wrr(ADDR_TX_CMD_STAT, {(k == 1) ? CMD_PURGE_ALL : CMD_PURGE_TX, 12'h000});
      setc(8'h00);
      rdc(ADDR_DAISY_CTRL, 16'h0004, 16'h0004);
    end
    wrr(ADDR_STAT_INT_CTRL, 16'haaa0);
    for (k = 0; k < 6; k++)
    begin
      pin(k, 1'b1);
      rdc(ADDR_MISC_STAT, pv(k, 1, 1), pv(k, 1, 0));
      rdc(ADDR_DAISY_CTRL, 16'h0002, 16'h0002);
      pin(k, 1'b0);
      wrr(ADDR_MISC_STAT, 16'h0000);
      rdc(ADDR_MISC_STAT, pv(k, 1, 1), pv(k, 1, 0));
      pin(k, 1'b1);
      pin(k, 1'b0);
      wrr(ADDR_MISC_STAT, pv(k, 1, 0));
      rdc(ADDR_MISC_STAT, pv(k, 1, 0), pv(k, 1, 0));
      wrr(ADDR_MISC_STAT, pv(k, 1, 0));
      rdc(ADDR_MISC_STAT, pv(k, 1, 1), pv(k, 0, 1));
      wrr(ADDR_DAISY_CTRL, 16'h0082);
    end
    seed = xs(seed);
    wrr(ADDR_STAT_INT_CTRL, {12'h000, seed[3:0]});
    pulse(8'h00, 4'hf);
    wrr(ADDR_STAT_INT_CTRL, 16'h0000);
    rdc(ADDR_MISC_STAT, 16'h000f, {12'h000, seed[3:0]});
    rdc(ADDR_DAISY_CTRL, 16'h0001, {15'h0000, |seed[3:0]});
    wrr(ADDR_STAT_INT_CTRL, 16'h000f);
    pulse(8'h00, 4'h1);
    pulse(8'h00, 4'h1);
    wrr(ADDR_MISC_STAT, 16'h000f);
    rdc(ADDR_MISC_STAT, 16'h000f, 16'h0001);
    wrr(ADDR_MISC_STAT, 16'h0001);
    rdc(ADDR_MISC_STAT, 16'h000f, 16'h0000);
    results();
  end
endmodule : stmis_top_test
